// ==== hdl/misc_exec_defines.vh ====
// constants for the miscellaneous instruction execution block
`ifndef MISC_EXEC_DEFINES_VH
`define MISC_EXEC_DEFINES_VH
`define OP_EI_HI 14'h1f01
`define OP_HALT 16'h7a00
`define OP_DECREMENT_BRANCH_NONZERO_HI 4'hf
`define OP_EXR_HI 7'h56
`define OP_EXIR_HI 7'h16
`define OP_SIGN_EXTEND_WORD_HI 8'hb1
`define OP_INIR_HI 7'h1e
`define OP_INDA_HI 7'h1d
`define SIGN_EXTEND_WORD_B 4'h0
`define SIGN_EXTEND_WORD_W 4'ha
`define SIGN_EXTEND_WORD_L 4'h7
`define FCW_NVI_BIT 11
`define FCW_VI_BIT 12
`define EI_CYCLES 4'h7
`define HALT_BASE 4'h8
`define HALT_PERIOD 2'h3
`define REFRESH_CNT 8'h3f
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_INSTR 4'h8
`define ADDR_RESULT 4'hc
`endif

// ==== hdl/halt_timer.v ====
// halt period timer: pulses every 3 cycles after the 8-cycle base
`timescale 1ns/1ps
`include "misc_exec_defines.vh"
module halt_timer (
  input wire core_clk,
  input wire reset_n,
  input wire run,
  output reg sample
);
  reg [3:0] base_r;
  reg [1:0] per_r;
  always @(posedge core_clk) begin
    if (!reset_n || !run) begin
      base_r <= 4'h0;
      per_r <= 2'h0;
      sample <= 1'b0;
    end else begin
      sample <= 1'b0;
      if (base_r != `HALT_BASE - 4'h1) begin
        base_r <= base_r + 4'h1;
        if (base_r == `HALT_BASE - 4'h2)
          sample <= 1'b1;
      end else if (per_r == `HALT_PERIOD - 2'h1) begin
        per_r <= 2'h0;
        sample <= 1'b1;
      end else begin
        per_r <= per_r + 2'h1;
      end
    end
  end
endmodule // halt_timer

// ==== hdl/misc_exec.v ====
// decode and execution of halt, interrupt enable, exchange, sign extend, input, loop
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "misc_exec_defines.vh"
// Function
// - interrupt enable sets nonvectored bit if bit0 zero, vectored if bit1 zero
// - a select bit of one leaves its bit; other control word bits untouched
// - decode interrupt enable from its fixed pattern; finishes in seven cycles
// - exchange swaps source and destination through a temporary register; the memory-source form only loads the word, memory is not written
// - sign extension copies low half sign into all high half bits
// - byte form on word, word form on pair, long form on quadruple
// - these instructions leave condition flags unchanged
// - halt suspends execution, holding state until interrupt or reset
// - after the interrupt that ends halt, resume at the next instruction
// - while halted, refresh continues and bus requests are granted
// - halted: interrupts sampled each 3-cycle period, 8+3n cycles total
// - input loads the addressed port contents into the destination
// - ordinary input uses standard I/O, special input uses special I/O status
// - direct-port input select bit: one special, zero standard
// - decrement counter; nonzero result branches, zero falls through
// - target is next address minus twice 7-bit displacement; segment kept
module misc_exec (
  input wire core_clk,
  input wire reset_n,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] mem_rdata,
  input wire [15:0] port_rdata,
  input wire int_request,
  input wire bus_request_in,
  output reg bus_grant,
  output reg refresh_strobe,
  output reg special_io,
  output reg io_read,
  output reg [15:0] io_addr
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_EXEC = 5'b00010;
  localparam ST_HALT = 5'b00100;
  localparam ST_IO = 5'b01000;
  localparam ST_DONE = 5'b10000;

  // machine state, sequencing and bus-port registers
  reg [15:0] instr_r;
  reg [15:0] port_r;
  reg [63:0] regs_r;
  reg [15:0] fcw_r;
  reg [15:0] pc_r;
  reg [15:0] tmp_r;
  reg [4:0] state_r;
  reg [3:0] cyc_r;
  reg go_r;
  reg [7:0] ref_r;
  reg aw_r, w_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  wire halt_sample;
  wire busy = state_r != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire is_ei = instr_r[15:2] == `OP_EI_HI;
  wire is_halt = instr_r == `OP_HALT;
  wire is_decrement_branch_nonzero = instr_r[15:12] == `OP_DECREMENT_BRANCH_NONZERO_HI;
  wire is_exr = instr_r[15:9] == `OP_EXR_HI;
  wire is_exir = instr_r[15:9] == `OP_EXIR_HI;
  wire is_sign_extend_word = instr_r[15:8] == `OP_SIGN_EXTEND_WORD_HI;
  wire is_inir = instr_r[15:9] == `OP_INIR_HI;
  wire is_inda = instr_r[15:9] == `OP_INDA_HI && instr_r[3:1] == 3'b010;
  // loop counter sits in bits 11:8 with its size bit at 7; sign extend and
  // direct-port input name their destination in bits 7:4
  wire size_byte = is_decrement_branch_nonzero ? instr_r[7] : instr_r[8];
  wire [1:0] rd = is_decrement_branch_nonzero ? instr_r[9:8] :
                  (is_sign_extend_word || is_inda) ? instr_r[5:4] : instr_r[1:0];
  wire [1:0] rs = instr_r[5:4];

  ////////////////////////////////////////////////////////////////////////////
  // register file view: four words
  wire [15:0] w0 = regs_r[15:0];
  wire [15:0] w1 = regs_r[31:16];
  wire [15:0] w2 = regs_r[47:32];
  wire [15:0] w3 = regs_r[63:48];
  reg [15:0] rd_val, rs_val;
  always @* begin
    case (rd)
      2'h0: rd_val = w0;
      2'h1: rd_val = w1;
      2'h2: rd_val = w2;
      default: rd_val = w3;
    endcase
    case (rs)
      2'h0: rs_val = w0;
      2'h1: rs_val = w1;
      2'h2: rs_val = w2;
      default: rs_val = w3;
    endcase
  end

  halt_timer u_halt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(state_r == ST_HALT),
    .sample(halt_sample)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready = !w_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_go = aw_r && w_r && !s_axi_bvalid;

  function [15:0] mrg;
    input [15:0] old;
    input [15:0] d;
    input [1:0] be;
    begin
      mrg = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge core_clk) begin
    if (!reset_n) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        wdata_r <= {s_axi_wstrb, s_axi_wdata[27:0]};
      end
      if (wr_go) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == `ADDR_CTRL || awaddr_r == `ADDR_INSTR ||
                        awaddr_r == `ADDR_RESULT) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `ADDR_CTRL: s_axi_rdata <= {16'h0, fcw_r};
          `ADDR_STATUS: s_axi_rdata <= {11'h0, state_r, pc_r};
          `ADDR_INSTR: s_axi_rdata <= {port_r, instr_r};
          `ADDR_RESULT: s_axi_rdata <= regs_r[31:0];
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution
  // wstrb is kept in the top nibble of wdata_r; data word needs raw wdata
  reg [31:0] wd_r;
  always @(posedge core_clk) begin
    if (!reset_n)
      wd_r <= 32'h0;
    else if (s_axi_wvalid && s_axi_wready)
      wd_r <= s_axi_wdata;
  end
  wire [3:0] be = wdata_r[31:28];

  wire [15:0] sign_extend_word_w = {{8{rd_val[7]}}, rd_val[7:0]};
  wire [15:0] decrement_branch_nonzero_cnt = size_byte ? {rd_val[15:8], rd_val[7:0] - 8'h1} :
                                     rd_val - 16'h1;
  wire decrement_branch_nonzero_zero = size_byte ? decrement_branch_nonzero_cnt[7:0] == 8'h0 : decrement_branch_nonzero_cnt == 16'h0;
  wire [15:0] decrement_branch_nonzero_tgt = pc_r - {8'h0, instr_r[6:0], 1'b0};

  task put_rd;
    input [15:0] v;
    begin
      case (rd)
        2'h0: regs_r[15:0] <= v;
        2'h1: regs_r[31:16] <= v;
        2'h2: regs_r[47:32] <= v;
        default: regs_r[63:48] <= v;
      endcase
    end
  endtask

  always @(posedge core_clk) begin
    if (!reset_n) begin
      instr_r <= 16'h0;
      port_r <= 16'h0;
      regs_r <= 64'h0;
      fcw_r <= 16'h0;
      pc_r <= 16'h0;
      tmp_r <= 16'h0;
      state_r <= ST_IDLE;
      cyc_r <= 4'h0;
      go_r <= 1'b0;
      ref_r <= 8'h0;
      refresh_strobe <= 1'b0;
      bus_grant <= 1'b0;
      special_io <= 1'b0;
      io_read <= 1'b0;
      io_addr <= 16'h0;
    end else begin
      ref_r <= (ref_r == `REFRESH_CNT) ? 8'h0 : ref_r + 8'h1;
      refresh_strobe <= ref_r == `REFRESH_CNT;
      bus_grant <= bus_request_in && (state_r == ST_IDLE || state_r == ST_HALT);
      go_r <= 1'b0;
      if (wr_go && !busy) begin
        case (awaddr_r)
          `ADDR_CTRL: fcw_r <= mrg(fcw_r, wd_r[15:0], be[1:0]);
          `ADDR_INSTR: begin
            instr_r <= mrg(instr_r, wd_r[15:0], be[1:0]);
            port_r <= mrg(port_r, wd_r[31:16], be[3:2]);
            go_r <= 1'b1;
          end
          `ADDR_RESULT: begin
            regs_r[15:0] <= mrg(regs_r[15:0], wd_r[15:0], be[1:0]);
            regs_r[31:16] <= mrg(regs_r[31:16], wd_r[31:16], be[3:2]);
          end
          default: ;
        endcase
      end
      io_read <= 1'b0;
      case (state_r)
        ST_IDLE: if (go_r) begin
          cyc_r <= 4'h1;
          pc_r <= pc_r + 16'h2;
          state_r <= is_halt ? ST_HALT : (is_inir || is_inda) ? ST_IO : ST_EXEC;
          if (is_inir || is_inda) begin
            io_read <= 1'b1;
            io_addr <= is_inir ? rs_val : port_r;
            special_io <= is_inda && instr_r[0];
          end
        end
        ST_EXEC: begin
          cyc_r <= cyc_r + 4'h1;
          if (cyc_r == 4'h1) begin
            // flags byte of control word is never written here
            if (is_ei) begin
              if (!instr_r[0]) fcw_r[`FCW_NVI_BIT] <= 1'b1;
              if (!instr_r[1]) fcw_r[`FCW_VI_BIT] <= 1'b1;
            end else if (is_exr || is_exir) begin
              tmp_r <= is_exr ? rs_val : mem_rdata;
            end else if (is_sign_extend_word) begin
              case (instr_r[3:0])
                `SIGN_EXTEND_WORD_B: put_rd(sign_extend_word_w);
                // even word of a pair is its high half
                `SIGN_EXTEND_WORD_W: begin
                  if (rd[1])
                    regs_r[47:32] <= {16{regs_r[63]}};
                  else
                    regs_r[15:0] <= {16{regs_r[31]}};
                end
                // quadruple: r0 and r1 form the high half, sign taken from r2
                `SIGN_EXTEND_WORD_L: regs_r[31:0] <= {32{regs_r[47]}};
                default: ;
              endcase
            end else if (is_decrement_branch_nonzero) begin
              put_rd(decrement_branch_nonzero_cnt);
              if (!decrement_branch_nonzero_zero) pc_r <= decrement_branch_nonzero_tgt;
            end
          end
          if (cyc_r == 4'h2 && (is_exr || is_exir)) begin
            if (is_exr) begin
              case (rs)
                2'h0: regs_r[15:0] <= size_byte ? {w0[15:8], rd_val[7:0]} : rd_val;
                2'h1: regs_r[31:16] <= size_byte ? {w1[15:8], rd_val[7:0]} : rd_val;
                2'h2: regs_r[47:32] <= size_byte ? {w2[15:8], rd_val[7:0]} : rd_val;
                default: regs_r[63:48] <= size_byte ? {w3[15:8], rd_val[7:0]} : rd_val;
              endcase
            end
          end
          if (cyc_r == 4'h3 && (is_exr || is_exir))
            put_rd(size_byte ? {rd_val[15:8], tmp_r[7:0]} : tmp_r);
          if (is_ei ? cyc_r == `EI_CYCLES - 4'h1 : cyc_r == 4'h3)
            state_r <= ST_DONE;
        end
        ST_HALT: begin
          // pc already points past halt; state is simply held
          if (halt_sample && int_request)
            state_r <= ST_DONE;
        end
        ST_IO: begin
          put_rd(size_byte ? {rd_val[15:8], port_rdata[7:0]} : port_rdata);
          state_r <= ST_DONE;
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // misc_exec

// ==== tb/misc_exec_chk.sv ====
// port-level assertions for the execution block
`timescale 1ns/1ps
module misc_exec_chk (
  input wire core_clk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire bus_request_in,
  input wire bus_grant,
  input wire refresh_strobe,
  input wire io_read
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_io_pulse:
    assert property (io_read |=> !io_read) else $error("io strobe too long");
  a_grant_cause:
    assert property (bus_grant |-> $past(bus_request_in)) else $error("grant without request");
  a_refresh_gap:
    assert property (refresh_strobe |=> !refresh_strobe [*8] ##56 refresh_strobe)
    else $error("refresh period wrong");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  a_read_lat:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_write_lat:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
  a_slverr_zero:
    assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read data not zero");
  c_io: cover property (io_read);
  c_grant: cover property (bus_grant);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // misc_exec_chk
bind misc_exec misc_exec_chk u_chk (.core_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .bus_request_in, .bus_grant,
  .refresh_strobe, .io_read);

// ==== tb/io_model.sv ====
// memory and port model on the far side of the execution block
`timescale 1ns/1ps
module io_model #(parameter logic [15:0] MEM_WORD = 16'h3c5a) (
  input wire logic core_clk,
  input wire logic io_read,
  input wire logic [15:0] io_addr,
  output logic [15:0] mem_rdata,
  output logic [15:0] port_rdata
);
  logic [15:0] junk_r = 16'h0f0f;
  assign mem_rdata = MEM_WORD;
  // port data stands only while the read strobe is high, toggling junk otherwise
  always @(posedge core_clk) begin
    junk_r <= ~junk_r;
  end
  assign port_rdata = io_read ? (io_addr ^ 16'ha5f0) : junk_r;
endmodule // io_model

// ==== tb/misc_exec_bench.sv ====
// self-checking bench for the execution block
`timescale 1ns/1ps
`include "misc_exec_defines.vh"
module misc_exec_bench;
  logic core_clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, int_request = 0, bus_request_in = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, st;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic bus_grant, refresh_strobe, special_io, io_read;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] mem_rdata, port_rdata, io_addr, pc, pv;
  logic [15:0] ops [6];
  logic [31:0] ini [6];
  logic [31:0] exp [6];
  int n_mismatch = 0, num_checks = 0, i;
  misc_exec u_dut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_rdata, .port_rdata, .int_request, .bus_request_in,
    .bus_grant, .refresh_strobe, .special_io, .io_read, .io_addr);
  io_model u_io (.core_clk, .io_read, .io_addr, .mem_rdata, .port_rdata);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bounded(int k, int lim);
    if (k >= lim) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic axw(logic [3:0] a, logic [31:0] v);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    bounded(k, 50);
  endtask
  task automatic axr(logic [3:0] a, output logic [31:0] v);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    resp = s_axi_rresp;
    bounded(k, 50);
  endtask
  // poll the one-hot state field until the given bit shows
  task automatic wait_state(int b);
    int k;
    for (k = 0; k < 100; k++) begin
      axr(`ADDR_STATUS, st);
      if (st[b] === 1'b1) break;
    end
    bounded(k, 100);
  endtask
  task automatic run(logic [15:0] op, logic [15:0] port);
    axw(`ADDR_INSTR, {port, op});
    repeat (2) @(posedge core_clk);
    wait_state(16);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ops = '{{`OP_EXR_HI, 1'b0, 4'd1, 4'd0}, {`OP_EXR_HI, 1'b1, 4'd9, 4'd8},
      {`OP_EXIR_HI, 1'b0, 4'd1, 4'd0}, {`OP_SIGN_EXTEND_WORD_HI, 4'd0, `SIGN_EXTEND_WORD_B},
      {`OP_SIGN_EXTEND_WORD_HI, 4'd0, `SIGN_EXTEND_WORD_W}, {`OP_SIGN_EXTEND_WORD_HI, 4'd0, `SIGN_EXTEND_WORD_L}};
    ini = '{32'h8001_1234, 32'h8001_1234, 32'h0002_1234, 32'h5555_0080, 32'h8000_1234, '1};
    exp = '{32'h1234_8001, 32'h8034_1201, 32'h0002_3c5a, 32'h5555_ff80, 32'h8000_ffff, 0};
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    axr(`ADDR_CTRL, d);
    check("ctrl reset", d, 32'h0);
    axr(4'h6, d);
    check("unmapped resp", resp, 2'b10);
    axw(`ADDR_STATUS, 32'h0);
    check("read-only write resp", resp, 2'b10);
    axw(`ADDR_CTRL, 32'h0);
    check("ctrl write resp", resp, 2'b00);
    for (i = 0; i < 8; i++) begin
      axw(`ADDR_CTRL, i[2] ? 32'h1c55 : 32'h0455);
      run({`OP_EI_HI, i[1:0]}, 16'h0);
      axr(`ADDR_CTRL, d);
      check("ei ctrl", d, (i[2] ? 32'h1c55 : 32'h0455) | (i[0] ? 0 : 32'h800)
        | (i[1] ? 0 : 32'h1000));
    end
    for (i = 0; i < 6; i++) begin
      axw(`ADDR_RESULT, ini[i]);
      run(ops[i], 16'h0);
      axr(`ADDR_RESULT, d);
      check("swap or extend", d, exp[i]);
    end
    for (i = 0; i < 3; i++) begin
      axw(`ADDR_RESULT, 32'h7777_7777);
      pv = (16'h0123 + i[15:0]) ^ 16'ha5f0;
      run({`OP_INDA_HI, i[1], i[1] ? 4'd8 : 4'd0, 3'b010, i[0]}, 16'h0123 + i[15:0]);
      check("port addr", io_addr, 16'h0123 + i[15:0]);
      check("special status", special_io, i[0]);
      axr(`ADDR_RESULT, d);
      check("port data", d, {16'h7777, i[1] ? {8'h77, pv[7:0]} : pv});
    end
    axw(`ADDR_RESULT, 32'h0456_7777);
    run({`OP_INIR_HI, 1'b0, 4'd1, 4'd0}, 16'h0);
    check("indirect port addr", io_addr, 16'h0456);
    check("indirect status", special_io, 1'b0);
    axr(`ADDR_RESULT, d);
    check("indirect data", d, {16'h0456, 16'h0456 ^ 16'ha5f0});
    axw(`ADDR_RESULT, 32'h0000_0002);
    for (i = 0; i < 2; i++) begin
      axr(`ADDR_STATUS, st);
      pc = st[15:0] + 16'd2 - (i == 0 ? 16'd6 : 16'd0);
      run({`OP_DECREMENT_BRANCH_NONZERO_HI, 4'd0, 1'b0, 7'd3}, 16'h0);
      axr(`ADDR_STATUS, d);
      check("loop pc", d[15:0], pc);
      axr(`ADDR_RESULT, d);
      check("loop count", d, 32'h1 - i);
    end
    axr(`ADDR_STATUS, st);
    pc = st[15:0] + 16'd2;
    axw(`ADDR_INSTR, {16'h0, `OP_HALT});
    repeat (30) @(posedge core_clk);
    bus_request_in <= 1'b1;
    wait_state(18);
    check("halt state", st[20:16], 5'h04);
    repeat (3) @(posedge core_clk);
    check("grant in halt", bus_grant, 1'b1);
    bus_request_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    int_request <= 1'b1;
    wait_state(16);
    int_request <= 1'b0;
    check("resume pc", st[15:0], pc);
    axr(`ADDR_CTRL, d);
    check("ctrl kept", d, 32'h1c55);
    tally_and_finish();
  end
endmodule // misc_exec_bench
